/* File: bench/tocs_assertions.sv */
`timescale 1ns/100ps
`default_nettype none
module tocs_assertions #(
	parameter int N_AXES = 6,
	parameter int AXIS_W = 3
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic [N_AXES-1:0] cutoff_in,
	input wire logic [N_AXES-1:0] fast_int_sel_in,
	input wire logic [N_AXES-1:0] fast_int_trig_in,
	input wire logic [N_AXES-1:0] sup_present_in,
	input wire logic [N_AXES-1:0] sup_enable_in,
	input wire logic [N_AXES-1:0] sup_reset_in,
	input wire logic enc_err_valid_in,
	input wire logic [AXIS_W-1:0] enc_err_axis_in,
	input wire logic [15:0] enc_err_code_in,
	input wire logic sys_err_valid_in,
	input wire logic [N_AXES-1:0] power_on_out,
	input wire logic [N_AXES-1:0] start_inhibit_out,
	input wire logic [N_AXES-1:0] fast_latched_out,
	input wire logic [N_AXES-1:0] enc_ok_out,
	input wire logic ctrl_alarm_out,
	input wire logic safe_out_enable_out,
	input wire logic alarm_valid_out,
	input wire logic alarm_enc_out,
	input wire logic [15:0] alarm_code_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (rst_in);
	wire lst = enc_err_code_in inside {[16'h0ce5:16'h0ce8],
		[16'h0ceb:16'h0cee], [16'h0cf9:16'h0cfb], [16'h0cff:16'h0d02]};
	wire ax0 = enc_err_valid_in && enc_err_axis_in == '0 && !sys_err_valid_in;
	wire on0 = sup_present_in[0] && sup_enable_in[0];
	wire sup0 = ax0 && on0 && lst;
	wire fp0 = fast_int_sel_in[0] && fast_int_trig_in[0];
	chk_cutoff_engage: assert property (
		1 |=> (~$past(cutoff_in) & (power_on_out | ~start_inhibit_out)) == '0)
		else $error("cutoff not engaged");
	chk_enc_alarm: assert property (
		ax0 && !on0 |=> alarm_valid_out && alarm_enc_out && ctrl_alarm_out
		&& alarm_code_out == $past(enc_err_code_in)) else $error("no alarm");
	chk_enc_suppress: assert property (
		sup0 && !ctrl_alarm_out |=> !alarm_valid_out && !ctrl_alarm_out)
		else $error("not suppressed");
	chk_ok_falls: assert property (
		sup0 ##1 !sup_reset_in[0] |=> !enc_ok_out[0]) else $error("ok high");
	chk_ok_latched: assert property (
		sup0 ##1 !sup_reset_in[0] [*4] |=> !enc_ok_out[0])
		else $error("ok recovered");
	// power follows the latch, so it drops one edge after the latch sets
	chk_fast_cut: assert property (
		fp0 [*3] |=> ##1 !power_on_out[0]) else $error("fast path slow");
	chk_fast_hold: assert property (
		fp0 [*4] |=> fast_latched_out[0]) else $error("latch lost");
	chk_alarm_hold: assert property (
		ctrl_alarm_out |-> !safe_out_enable_out && power_on_out == '0
		##1 ctrl_alarm_out) else $error("alarm left");
	cover property (sup0);
	cover property (ax0 && !on0);
	cover property (fast_latched_out[0]);
endmodule
bind tocs_top tocs_assertions #(.N_AXES(N_AXES), .AXIS_W(AXIS_W))
	tocs_assertions_inst (
	.clk_in(clk_in),
	.rst_in(rst_in),
	.cutoff_in(cutoff_in),
	.fast_int_sel_in(fast_int_sel_in),
	.fast_int_trig_in(fast_int_trig_in),
	.sup_present_in(sup_present_in),
	.sup_enable_in(sup_enable_in),
	.sup_reset_in(sup_reset_in),
	.enc_err_valid_in(enc_err_valid_in),
	.enc_err_axis_in(enc_err_axis_in),
	.enc_err_code_in(enc_err_code_in),
	.sys_err_valid_in(sys_err_valid_in),
	.power_on_out(power_on_out),
	.start_inhibit_out(start_inhibit_out),
	.fast_latched_out(fast_latched_out),
	.enc_ok_out(enc_ok_out),
	.ctrl_alarm_out(ctrl_alarm_out),
	.safe_out_enable_out(safe_out_enable_out),
	.alarm_valid_out(alarm_valid_out),
	.alarm_enc_out(alarm_enc_out),
	.alarm_code_out(alarm_code_out)
);
`default_nettype wire

/* File: bench/tocs_far.sv */
`timescale 1ns/100ps
`default_nettype none
module tocs_far (
	input wire logic clk_in,
	input wire logic [5:0] ack_req_in,
	input wire logic [5:0] clr_req_in,
	output var logic [5:0] fast_ack_out,
	output var logic [5:0] sup_reset_out
);
	// program logic answers one scan after its decision, never sooner
	always @(posedge clk_in) begin
		fast_ack_out <= ack_req_in;
		sup_reset_out <= clr_req_in;
	end
endmodule
`default_nettype wire

/* File: bench/tocs_top_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module tocs_top_tb_top;
	logic clk_in = 0, rst_in = 1, supply_ok_in = 1, fast_ext_trig_in = 0, s;
	logic enc_err_valid_in = 0, sys_err_valid_in = 0, ctrl_alarm_out;
	logic safe_out_enable_out, alarm_valid_out, alarm_enc_out;
	logic [5:0] cutoff_in = '1, quick_stop_in = '0, fast_int_sel_in = '0;
	logic [5:0] fast_ext_sel_in = '0, fast_int_trig_in = '0, ack = '0;
	logic [5:0] clr = '0, sup_present_in = '1, sup_enable_in = '1;
	logic [5:0] enc_err_present_in = '0, fast_ack_in, sup_reset_in;
	logic [5:0] power_on_out, start_inhibit_out, ready_out;
	logic [5:0] fast_latched_out, enc_ok_out;
	logic [2:0] enc_err_axis_in = '0;
	logic [15:0] enc_err_code_in = '0, sys_err_code_in = '0, alarm_code_out;
	logic [31:0] seed = 32'h0000_0050;
	int miscompares = 0, n_tests = 0, cyc = 0;
	tocs_top tocs_top_inst (.*);
	tocs_far tocs_far_inst (.clk_in(clk_in), .ack_req_in(ack),
		.clr_req_in(clr), .fast_ack_out(fast_ack_in),
		.sup_reset_out(sup_reset_in));
	function automatic logic [31:0] xs(input logic [31:0] v);
		v ^= v << 13;
		v ^= v >> 17;
		return v ^ (v << 5);
	endfunction
	task automatic chk(input string n, input logic [15:0] e,
		input logic [15:0] g);
		n_tests++;
		if (g !== e) begin
			miscompares++;
			$display("BAD %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask
	task automatic end_sim;
		if (miscompares == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial forever #25 clk_in = ~clk_in;
	always @(posedge clk_in) begin
		cyc++;
		if (cyc > 3000) begin
			miscompares++;
			end_sim();
		end
	end
	initial begin
		tick(16);
		rst_in = 0;
		repeat (40) begin
			seed = xs(seed);
			{supply_ok_in, quick_stop_in, cutoff_in} = seed[12:0];
			tick(2);
			chk("pwr", 16'(cutoff_in), 16'(power_on_out));
			chk("rdy", 16'(cutoff_in & ~quick_stop_in & {6{supply_ok_in}}),
				16'(ready_out));
			chk("inh", 16'(6'(~cutoff_in)), 16'(start_inhibit_out));
		end
		cutoff_in = '1;
		{fast_int_sel_in, fast_ext_sel_in, fast_int_trig_in} = 18'h0_1081;
		fast_ext_trig_in = 1;
		tick(5);
		chk("fcut", 16'h003c, 16'(power_on_out));
		ack = '1;
		tick(3);
		chk("fheld", 16'h0003, 16'(fast_latched_out));
		{fast_int_trig_in, fast_ext_trig_in} = '0;
		tick(6);
		chk("fclr", 16'h003f, 16'(power_on_out));
		// codes just outside the lists must still raise the alarm
		for (int c = 16'h0ce4; c <= 16'h0d03; c++) begin
			rst_in = 1;
			tick(1);
			rst_in = 0;
			seed = xs(seed);
			enc_err_axis_in = seed[2:0];
			sup_enable_in = seed[13:8];
			sup_present_in = seed[19:14] | seed[25:20];
			enc_err_code_in = 16'(c);
			// axes 6 and 7 have no slot and can never be suppressed
			s = (c inside {[16'h0ce5:16'h0ce8], [16'h0ceb:16'h0cee],
				[16'h0cf9:16'h0cfb], [16'h0cff:16'h0d02]})
				&& enc_err_axis_in < 3'h6
				&& sup_present_in[enc_err_axis_in]
				&& sup_enable_in[enc_err_axis_in];
			enc_err_valid_in = 1;
			tick(1);
			enc_err_valid_in = 0;
			chk("aenc", 16'(!s), 16'(alarm_enc_out));
			chk("acode", s ? '0 : 16'(c), alarm_code_out);
			tick(1);
			chk("run", 16'(!s), 16'(ctrl_alarm_out));
			chk("safe", 16'(s), 16'(safe_out_enable_out));
			if (s)
				chk("ok", 16'h0000, 16'(enc_ok_out[enc_err_axis_in]));
		end
		// a fault from outside the encoder path: plain code, no prefix
		rst_in = 1;
		tick(1);
		rst_in = 0;
		seed = xs(seed);
		sys_err_code_in = seed[15:0];
		sys_err_valid_in = 1;
		tick(1);
		sys_err_valid_in = 0;
		chk("senc", 16'h0000, 16'(alarm_enc_out));
		chk("scode", sys_err_code_in, alarm_code_out);
		chk("spwr", 16'h0000, 16'(power_on_out));
		tick(1);
		chk("sval", 16'h0000, 16'(alarm_valid_out));
		// suppressed fault on axis 0, then the program reset sequence
		rst_in = 1;
		tick(1);
		rst_in = 0;
		{sup_present_in, sup_enable_in} = '1;
		enc_err_axis_in = '0;
		enc_err_code_in = 16'h0ced;
		enc_err_present_in = 6'h01;
		enc_err_valid_in = 1;
		tick(1);
		enc_err_valid_in = 0;
		tick(5);
		chk("kept", 16'h0000, 16'(enc_ok_out[0]));
		chk("stay", 16'h0000, 16'(ctrl_alarm_out));
		clr = 6'h01;
		tick(4);
		chk("held", 16'h0000, 16'(enc_ok_out[0]));
		// drop the request first so it cannot meet the cleared condition
		clr = '0;
		tick(2);
		enc_err_present_in = '0;
		tick(4);
		chk("idle", 16'h0000, 16'(enc_ok_out[0]));
		clr = 6'h01;
		tick(1);
		clr = '0;
		tick(3);
		chk("back", 16'h0001, 16'(enc_ok_out[0]));
		end_sim();
	end
endmodule
`default_nettype wire

/* File: rtl/tocs_enc_if.sv */
`timescale 1ns/100ps
`default_nettype none
interface tocs_enc_if;
	import tocs_pkg::*;
	logic err_valid;
	logic [TOCS_CODE_W-1:0] err_code;
	logic err_present;
	logic present;
	logic enable;
	logic reset_req;
	logic status;
	logic suppress;
	modport sup (input err_valid, err_code, err_present, present, enable,
		reset_req, output status, suppress);
	modport ctl (output err_valid, err_code, err_present, present, enable,
		reset_req, input status, suppress);
endinterface
`default_nettype wire

/* File: rtl/tocs_enc_sup.sv */
`timescale 1ns/100ps
`default_nettype none
module tocs_enc_sup
	import tocs_pkg::*;
(
	input wire logic clk_in,
	input wire logic rst_in,
	tocs_enc_if.sup bus
);
	logic fault;
	logic listed;

	assign listed = tocs_listed(bus.err_code);

	// a new listed error in the same cycle as the program reset keeps the fault
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			fault <= 1'b0;
		end else if (bus.err_valid && listed) begin
			fault <= 1'b1;
		end else if (bus.reset_req && !bus.err_present) begin
			fault <= 1'b0; // RULE14 RULE16
		end
	end

	assign bus.status = bus.present && bus.enable && !fault; // RULE8
	// only an enabled supervisor hides the error from the controller
	assign bus.suppress = bus.present && bus.enable && listed; // RULE7 RULE9
endmodule
`default_nettype wire

/* File: rtl/tocs_pkg.sv */
// What this block does
// (RULE1) six cutoff and six supervisor slots, one per axis
// (RULE2) cutoff input low engages, high releases
// (RULE3) engaged cutoff removes motor power path
// (RULE4) ready when released, no quick stop, supply good
// (RULE5) optional internal and external fast path triggers
// (RULE6) unsuppressed encoder error: run to alarm, outputs off
// (RULE7) enabled supervisor keeps controller running on error
// (RULE8) supervisor output high when enabled and fault free
// (RULE9) disabled supervisor suppresses nothing, alarm raised
// (RULE10) encoder alarms carry prefix E with code
// (RULE11) max speed codes 3309/3310, 3329/3330 suppressible
// (RULE12) sensor comparison codes suppressible, both axes
// (RULE13) section length codes 3307/3308, 3327/3328 suppressible
// (RULE14) fault gone plus program reset restores output
// (RULE15) fast trigger latched until acknowledged after clearing
// (RULE16) supervisor output never recovers without reset
package tocs_pkg;
	localparam int TOCS_AXES = 6;
	localparam int TOCS_CODE_W = 16;
	localparam int TOCS_NCODES = 16;
	localparam logic [TOCS_CODE_W-1:0] TOCS_CODES [TOCS_NCODES] = '{
		16'h0CED, 16'h0CEE, 16'h0D01, 16'h0D02,
		16'h0CE5, 16'h0CE6, 16'h0CF9, 16'h0CFA,
		16'h0CE7, 16'h0CE8, 16'h0CFA, 16'h0CFB,
		16'h0CEB, 16'h0CEC, 16'h0CFF, 16'h0D00
	};
	localparam logic [TOCS_CODE_W-1:0] TOCS_CODE_RST = 16'h0000;

	typedef enum logic [0:0] {
		TOCS_RUN = 1'b0,
		TOCS_ALARM = 1'b1
	} tocs_ctrl_t;

	function automatic logic tocs_listed(input logic [TOCS_CODE_W-1:0] c);
		logic hit;
		hit = 1'b0;
		for (int k = 0; k < TOCS_NCODES; k++) begin
			if (TOCS_CODES[k] == c) begin
				hit = 1'b1; // RULE11 RULE12 RULE13
			end
		end
		return hit;
	endfunction
endpackage

/* File: rtl/tocs_top.sv */
`timescale 1ns/100ps
`default_nettype none
module tocs_top
	import tocs_pkg::*;
#(
	parameter int N_AXES = TOCS_AXES,
	parameter int AXIS_W = $clog2(TOCS_AXES)
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic [N_AXES-1:0] cutoff_in,
	input wire logic [N_AXES-1:0] quick_stop_in,
	input wire logic supply_ok_in,
	input wire logic [N_AXES-1:0] fast_int_sel_in,
	input wire logic [N_AXES-1:0] fast_ext_sel_in,
	input wire logic [N_AXES-1:0] fast_int_trig_in,
	input wire logic fast_ext_trig_in,
	input wire logic [N_AXES-1:0] fast_ack_in,
	input wire logic [N_AXES-1:0] sup_present_in,
	input wire logic [N_AXES-1:0] sup_enable_in,
	input wire logic [N_AXES-1:0] sup_reset_in,
	input wire logic [N_AXES-1:0] enc_err_present_in,
	input wire logic enc_err_valid_in,
	input wire logic [AXIS_W-1:0] enc_err_axis_in,
	input wire logic [TOCS_CODE_W-1:0] enc_err_code_in,
	input wire logic sys_err_valid_in,
	input wire logic [TOCS_CODE_W-1:0] sys_err_code_in,
	output logic [N_AXES-1:0] power_on_out,
	output logic [N_AXES-1:0] start_inhibit_out,
	output logic [N_AXES-1:0] ready_out,
	output logic [N_AXES-1:0] fast_latched_out,
	output logic [N_AXES-1:0] enc_ok_out,
	output logic ctrl_alarm_out,
	output logic safe_out_enable_out,
	output logic alarm_valid_out,
	output logic alarm_enc_out,
	output logic [TOCS_CODE_W-1:0] alarm_code_out
);
	tocs_ctrl_t state;
	tocs_ctrl_t next_state;
	logic [N_AXES-1:0] int_meta;
	logic [N_AXES-1:0] int_sync;
	logic ext_meta;
	logic ext_sync;
	logic [N_AXES-1:0] fast_lat;
	logic [N_AXES-1:0] sup_vec;
	logic enc_alarm;
	logic any_alarm;

	tocs_enc_if enc_bus[N_AXES]();

	// fast triggers are pins: two flops before anything reads them
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			int_meta <= '0;
			int_sync <= '0;
			ext_meta <= 1'b0;
			ext_sync <= 1'b0;
		end else begin
			int_meta <= fast_int_trig_in;
			int_sync <= int_meta;
			ext_meta <= fast_ext_trig_in;
			ext_sync <= ext_meta;
		end
	end

	// one cutoff and one supervisor per axis, never more
	for (genvar i = 0; i < N_AXES; i++) begin : g_axis // RULE1
		logic trig;
		logic engaged;

		// internal path from this unit, external from all the others
		assign trig = (fast_int_sel_in[i] && int_sync[i]) ||
			(fast_ext_sel_in[i] && ext_sync); // RULE5

		// set wins: an ack while the trigger still stands is ignored
		always_ff @(posedge clk_in or posedge rst_in) begin
			if (rst_in) begin
				fast_lat[i] <= 1'b0;
			end else if (trig) begin
				fast_lat[i] <= 1'b1; // RULE15
			end else if (fast_ack_in[i]) begin
				fast_lat[i] <= 1'b0; // RULE15
			end
		end

		// alarm state also drops power, like every other safe output
		assign engaged = !cutoff_in[i] || fast_lat[i] ||
			(next_state == TOCS_ALARM); // RULE2

		always_ff @(posedge clk_in or posedge rst_in) begin
			if (rst_in) begin
				power_on_out[i] <= 1'b0;
				start_inhibit_out[i] <= 1'b1;
				ready_out[i] <= 1'b0;
				fast_latched_out[i] <= 1'b0;
			end else begin
				power_on_out[i] <= !engaged; // RULE3
				start_inhibit_out[i] <= engaged; // RULE4
				ready_out[i] <= !engaged && !quick_stop_in[i] &&
					supply_ok_in; // RULE4
				fast_latched_out[i] <= fast_lat[i];
			end
		end

		assign enc_bus[i].err_valid = enc_err_valid_in &&
			(enc_err_axis_in == AXIS_W'(i));
		assign enc_bus[i].err_code = enc_err_code_in;
		assign enc_bus[i].err_present = enc_err_present_in[i];
		assign enc_bus[i].present = sup_present_in[i];
		assign enc_bus[i].enable = sup_enable_in[i];
		assign enc_bus[i].reset_req = sup_reset_in[i];
		assign sup_vec[i] = enc_bus[i].suppress;

		tocs_enc_sup u_sup (
			.clk_in(clk_in),
			.rst_in(rst_in),
			.bus(enc_bus[i])
		);

		always_ff @(posedge clk_in or posedge rst_in) begin
			if (rst_in) begin
				enc_ok_out[i] <= 1'b0;
			end else begin
				enc_ok_out[i] <= enc_bus[i].status; // RULE8
			end
		end
	end

	// an axis index beyond the last slot can never be suppressed
	always_comb begin
		enc_alarm = enc_err_valid_in;
		if (enc_err_valid_in && (int'(enc_err_axis_in) < N_AXES)) begin
			enc_alarm = !sup_vec[enc_err_axis_in]; // RULE6 RULE7 RULE9
		end
	end

	assign any_alarm = enc_alarm || sys_err_valid_in;

	// alarm is left only by a full reset of the controller
	always_comb begin
		next_state = state;
		unique case (state)
			TOCS_RUN: begin
				if (any_alarm) begin
					next_state = TOCS_ALARM; // RULE6 RULE9
				end
			end
			TOCS_ALARM: begin
				next_state = TOCS_ALARM;
			end
		endcase
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			state <= TOCS_RUN;
			ctrl_alarm_out <= 1'b0;
			safe_out_enable_out <= 1'b0;
		end else begin
			state <= next_state;
			ctrl_alarm_out <= (next_state == TOCS_ALARM);
			// outputs die in the same edge the alarm is taken
			safe_out_enable_out <= (next_state == TOCS_RUN); // RULE6
		end
	end

	// encoder alarms take priority when both sources fire together
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			alarm_valid_out <= 1'b0;
			alarm_enc_out <= 1'b0;
			alarm_code_out <= TOCS_CODE_RST;
		end else begin
			alarm_valid_out <= any_alarm;
			alarm_enc_out <= enc_alarm; // RULE10
			if (enc_alarm) begin
				alarm_code_out <= enc_err_code_in; // RULE10
			end else if (sys_err_valid_in) begin
				alarm_code_out <= sys_err_code_in;
			end
		end
	end
endmodule
`default_nettype wire
